// ===== rtl/bfa_ctrl.sv
// Purpose: fault latch, alert, balance, output gating and host reset
// Assumes: comparator levels are asynchronous and pass two flops
// Notes: open-drain pins are shown only by their pull-down enables
//
// Operation
// - gain bit picks gain 50 or 10
// - current pin off unless enabled; cal selects offset
// - disabled current pin tied to ground
// - host mode: bypass follows select bits
// - stand-alone: overvoltage stops charge, bypasses those cells
// - bypass ends at hysteresis; all stop on release
// - never bypass two adjacent cells together
// - bypass forced off during monitor intervals
// - thermistor drive only from its enable bit
// - thermistor low: both drives off, flag set
// - aux open-drain from its control bit, except in stand-alone zero-volt charge
// - stand-alone zero-volt charge uses aux for precharge
// - alert low whenever any fault detected
// - stand-alone alert releases when faults clear
// - host mode faults latched until toggle completes
// - status read after unlatch releases alert
// - latch-clear ignored during over/undervoltage; host waits
// - host reset held low after regulator start
// - host reset low while regulator out of spec
`timescale 1ns/10ps
module bfa_ctrl
  import bfa_pkg::*;
#(
  parameter int P_RST_CYC = RST_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // register port
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DW-1:0] o_rdata,
  // analog comparators, asynchronous
  input wire bfa_pins_t i_pins,
  input wire bfa_cells_t i_cells,
  // current monitor
  output logic o_current_gain_sel,
  output logic o_current_amp_en,
  output logic o_current_offset_cal,
  output logic o_current_out_pin_gnd,
  // cell bypass switches
  output logic [NCELL-1:0] o_bypass_sel,
  // switch drives, high turns the switch on
  output logic o_charge_switch_drive,
  output logic o_discharge_switch_drive,
  // thermistor and aux open drain
  output logic o_thermistor_drive,
  output logic o_aux_open_drain_out_oe,
  // host signals
  output logic o_host_alert_n,
  output logic o_host_reset_n_oe
);

  // synchronisers
  bfa_pins_t pins_m_q;
  bfa_pins_t pins_q;
  bfa_cells_t cells_m_q;
  bfa_cells_t cells_q;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pins_m_q <= '0;
      pins_q <= '0;
      cells_m_q <= '0;
      cells_q <= '0;
    end else begin
      pins_m_q <= i_pins;
      pins_q <= pins_m_q;
      cells_m_q <= i_cells;
      cells_q <= cells_m_q;
    end
  end

  // registers
  logic [DW-1:0] out_ctrl_q;
  logic [DW-1:0] state_ctrl_q;
  logic [DW-1:0] func_ctrl_q;
  logic [DW-1:0] cell_bal_q;
  logic host_mode;
  logic wr_oc;

  assign host_mode = state_ctrl_q[SC_HOST];
  assign wr_oc = i_wr && (i_addr == A_OUT_CTRL);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      out_ctrl_q <= OUT_CTRL_RST;
      state_ctrl_q <= STATE_CTRL_RST;
      func_ctrl_q <= FUNC_CTRL_RST;
      cell_bal_q <= CELL_BAL_RST;
    end else if (i_wr) begin
      case (i_addr)
        A_OUT_CTRL: out_ctrl_q <= i_wdata;
        A_STATE_CTRL: state_ctrl_q <= i_wdata;
        A_FUNC_CTRL: func_ctrl_q <= i_wdata;
        A_CELL_BAL: cell_bal_q <= i_wdata;
        default: ;
      endcase
    end
  end

  // fault conditions
  bfa_flt_t cur;
  bfa_flt_t cur_q;
  bfa_flt_t lat_q;
  logic ov_any;
  logic fault_rise;

  always_comb begin
    ov_any = |cells_q.ov;
    cur.ot = pins_q.therm_low;
    cur.uv = pins_q.uv;
    cur.ov = ov_any;
    cur.discharge_short = pins_q.discharge_short;
    cur.discharge_overcurrent = pins_q.discharge_overcurrent;
    fault_rise = |(cur & ~cur_q);
  end

  // latch-clear toggle detector
  logic lc_block;
  logic armed_q;
  logic toggle_done;

  // clear changes ignored while over/undervoltage is seen
  assign lc_block = ov_any || pins_q.uv;
  assign toggle_done = wr_oc && !lc_block && armed_q &&
                       !i_wdata[OC_LTCH];

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      armed_q <= 1'b0;
    end else if (wr_oc && !lc_block) begin
      armed_q <= i_wdata[OC_LTCH];
    end
  end

  // fault latches, set wins over the toggle
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lat_q <= '0;
      cur_q <= '0;
    end else begin
      cur_q <= cur;
      if (!host_mode) begin
        lat_q <= cur;
      end else if (toggle_done) begin
        lat_q <= cur;
      end else begin
        lat_q <= lat_q | cur;
      end
    end
  end

  // alert
  logic unlat_q;
  logic alert_n_q;
  logic st_rd;

  assign st_rd = i_rd && (i_addr == A_STATUS);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      unlat_q <= 1'b0;
      alert_n_q <= 1'b1;
    end else if (!host_mode) begin
      unlat_q <= 1'b0;
      alert_n_q <= ~|cur;
    end else if (fault_rise) begin
      // a new fault beats a release in the same cycle
      alert_n_q <= 1'b0;
      unlat_q <= toggle_done;
    end else if (toggle_done) begin
      unlat_q <= 1'b1;
    end else if (st_rd && unlat_q && (lat_q == '0)) begin
      alert_n_q <= 1'b1;
      unlat_q <= 1'b0;
    end
  end

  // adjacency filter, higher cells win, never next to held ones
  function automatic logic [NCELL-1:0] nonadj(
    input logic [NCELL-1:0] keep,
    input logic [NCELL-1:0] want
  );
    logic [NCELL-1:0] g;
    logic up;
    logic dn;
    g = '0;
    for (int i = NCELL - 1; i >= 0; i--) begin
      up = (i < NCELL - 1) ? (keep[i+1] | g[i+1]) : 1'b0;
      dn = (i > 0) ? keep[i-1] : 1'b0;
      g[i] = want[i] & ~keep[i] & ~up & ~dn;
    end
    return keep | g;
  endfunction

  // stand-alone balancing state
  logic [NCELL-1:0] sa_bal_q;
  logic [NCELL-1:0] sa_keep;
  logic [NCELL-1:0] host_sel;
  logic [NCELL-1:0] bal_sel;
  logic ov_prot_q;

  always_comb begin
    sa_keep = sa_bal_q & cells_q.hi;
    host_sel = {func_ctrl_q[FC_BAL10], func_ctrl_q[FC_BAL9],
                cell_bal_q};
    bal_sel = host_mode ? nonadj('0, host_sel) : sa_bal_q;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ov_prot_q <= 1'b0;
      sa_bal_q <= '0;
    end else if (host_mode) begin
      ov_prot_q <= 1'b0;
      sa_bal_q <= '0;
    end else begin
      // protection holds until no cell is over and none is bypassed
      ov_prot_q <= ov_any || (ov_prot_q && (sa_keep != '0));
      if (ov_any || ov_prot_q) begin
        sa_bal_q <= nonadj(sa_keep, cells_q.ov);
      end else begin
        sa_bal_q <= '0;
      end
    end
  end

  // host reset timer
  logic [RCW-1:0] rst_cnt_q;
  logic rst_done;

  assign rst_done = rst_cnt_q == RCW'(P_RST_CYC);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_cnt_q <= '0;
    end else if (!pins_q.reg_ok) begin
      rst_cnt_q <= '0;
    end else if (!rst_done) begin
      rst_cnt_q <= rst_cnt_q + 1'b1;
    end
  end

  // switch drives
  logic chg_d;
  logic dsg_d;

  always_comb begin
    if (host_mode) begin
      chg_d = out_ctrl_q[OC_CHG] & ~lat_q.ov & ~lat_q.discharge_overcurrent &
              ~lat_q.discharge_short;
      dsg_d = out_ctrl_q[OC_DSG] & ~lat_q.uv & ~lat_q.discharge_overcurrent &
              ~lat_q.discharge_short;
    end else begin
      chg_d = ~(ov_any | ov_prot_q | cur.discharge_overcurrent | cur.discharge_short);
      dsg_d = ~(cur.uv | cur.discharge_overcurrent | cur.discharge_short);
    end
    // thermistor trip and a dead regulator override both modes
    chg_d = chg_d & ~pins_q.therm_low & pins_q.reg_ok;
    dsg_d = dsg_d & ~pins_q.therm_low & pins_q.reg_ok;
  end

  // output flops
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_current_gain_sel <= 1'b0;
      o_current_amp_en <= 1'b0;
      o_current_offset_cal <= 1'b0;
      o_current_out_pin_gnd <= 1'b1;
      o_bypass_sel <= '0;
      o_charge_switch_drive <= 1'b0;
      o_discharge_switch_drive <= 1'b0;
      o_thermistor_drive <= 1'b0;
      o_aux_open_drain_out_oe <= 1'b0;
      o_host_alert_n <= 1'b1;
      o_host_reset_n_oe <= 1'b1;
    end else begin
      o_current_gain_sel <= state_ctrl_q[SC_GAIN];
      o_current_amp_en <= func_ctrl_q[FC_AMP_EN];
      o_current_offset_cal <= func_ctrl_q[FC_AMP_EN] &
                              func_ctrl_q[FC_OFS_CAL];
      o_current_out_pin_gnd <= ~func_ctrl_q[FC_AMP_EN];
      o_bypass_sel <= pins_q.mon_active ? '0 : bal_sel;
      o_charge_switch_drive <= chg_d;
      o_discharge_switch_drive <= dsg_d;
      // host owns the enable in host mode too
      o_thermistor_drive <= func_ctrl_q[FC_THERM];
      if (!host_mode && pins_q.zero_volt_charge_en) begin
        // precharge path on while the pack sits undervoltage
        o_aux_open_drain_out_oe <= pins_q.uv;
      end else begin
        o_aux_open_drain_out_oe <= out_ctrl_q[OC_AUX];
      end
      o_host_alert_n <= alert_n_q;
      o_host_reset_n_oe <= !(pins_q.reg_ok && rst_done);
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      case (i_addr)
        A_STATUS: o_rdata <= {host_mode, unlat_q, ~alert_n_q, lat_q};
        A_OUT_CTRL: o_rdata <= out_ctrl_q;
        A_STATE_CTRL: o_rdata <= state_ctrl_q;
        A_FUNC_CTRL: o_rdata <= func_ctrl_q;
        A_CELL_BAL: o_rdata <= cell_bal_q;
        default: o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

endmodule

// ===== rtl/bfa_pkg.sv
// Purpose: shared constants and types for the fault, alert and balance block
// Assumes: 8-bit register port, one 250 MHz clock domain
// Notes: register offsets are register indices on the plain port
package bfa_pkg;

  localparam int DW = 8;
  localparam int AW = 4;
  localparam int NCELL = 10;

  // register offsets
  localparam logic [AW-1:0] A_STATUS = 4'h0;
  localparam logic [AW-1:0] A_OUT_CTRL = 4'h1;
  localparam logic [AW-1:0] A_STATE_CTRL = 4'h2;
  localparam logic [AW-1:0] A_FUNC_CTRL = 4'h3;
  localparam logic [AW-1:0] A_CELL_BAL = 4'h4;

  // status fields
  localparam int ST_OCD = 0;
  localparam int ST_SCD = 1;
  localparam int ST_OV = 2;
  localparam int ST_UV = 3;
  localparam int ST_OT = 4;
  localparam int ST_ALERT = 5;
  localparam int ST_UNLAT = 6;
  localparam int ST_HOST = 7;

  // output control fields
  localparam int OC_DSG = 0;
  localparam int OC_CHG = 1;
  localparam int OC_LTCH = 2;
  localparam int OC_AUX = 3;

  // state control fields
  localparam int SC_GAIN = 0;
  localparam int SC_HOST = 7;

  // function control fields
  localparam int FC_AMP_EN = 0;
  localparam int FC_OFS_CAL = 1;
  localparam int FC_THERM = 2;
  localparam int FC_BAL9 = 3;
  localparam int FC_BAL10 = 4;

  // reset values
  localparam logic [DW-1:0] OUT_CTRL_RST = 8'h00;
  localparam logic [DW-1:0] STATE_CTRL_RST = 8'h00;
  localparam logic [DW-1:0] FUNC_CTRL_RST = 8'h00;
  localparam logic [DW-1:0] CELL_BAL_RST = 8'h00;

  // amplifier gains selected by the gain bit
  localparam int GAIN_HI = 50;
  localparam int GAIN_LO = 10;

  // host reset hold time
  localparam int CLK_MHZ = 250;
  localparam int RST_HOLD_US = 1000;
  localparam int RST_CYC = RST_HOLD_US * CLK_MHZ;
  localparam int RCW = 18;

  // analog comparator levels from the front end
  typedef struct packed {
    logic discharge_overcurrent;
    logic discharge_short;
    logic uv;
    logic therm_low;
    logic mon_active;
    logic reg_ok;
    logic zero_volt_charge_en;
  } bfa_pins_t;

  // per cell: above threshold, above threshold minus hysteresis
  typedef struct packed {
    logic [NCELL-1:0] ov;
    logic [NCELL-1:0] hi;
  } bfa_cells_t;

  // fault group, status bit order
  typedef struct packed {
    logic ot;
    logic uv;
    logic ov;
    logic discharge_short;
    logic discharge_overcurrent;
  } bfa_flt_t;

endpackage

// ===== test/bfa_chk_asserts.sv
// Purpose: port assertions for the fault, alert and balance block
// Assumes: a pin held four cycles has reached most outputs, alert five
// Notes: bound to every instance
`timescale 1ns/10ps
module bfa_chk
  import bfa_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire bfa_pins_t i_pins,
  input wire logic o_current_gain_sel,
  input wire logic o_current_amp_en,
  input wire logic o_current_offset_cal,
  input wire logic o_current_out_pin_gnd,
  input wire logic [NCELL-1:0] o_bypass_sel,
  input wire logic o_charge_switch_drive,
  input wire logic o_discharge_switch_drive,
  input wire logic o_host_alert_n,
  input wire logic o_host_reset_n_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  chk_gain_follow: assert property (
    i_wr && i_addr == A_STATE_CTRL |->
    ##2 o_current_gain_sel == $past(i_wdata[SC_GAIN], 2))
    else $error("gain select not following its bit");
  chk_cal_gate: assert property (
    o_current_offset_cal |-> o_current_amp_en)
    else $error("offset shown while amplifier off");
  chk_gnd_tie: assert property (
    o_current_out_pin_gnd == !o_current_amp_en)
    else $error("current pin ground tie wrong");
  chk_no_adjacent: assert property (
    (o_bypass_sel & (o_bypass_sel >> 1)) == '0)
    else $error("two adjacent cells bypassed");
  chk_mon_off: assert property (
    i_pins.mon_active [*4] |-> o_bypass_sel == '0)
    else $error("bypass on while monitoring");
  chk_therm_off: assert property (
    i_pins.therm_low [*4] |->
    !o_charge_switch_drive && !o_discharge_switch_drive)
    else $error("switch drive on while too hot");
  chk_alert_on: assert property (
    i_pins.discharge_overcurrent [*5] |-> !o_host_alert_n)
    else $error("alert released during a fault");
  chk_hrst_hold: assert property (
    $fell(o_host_reset_n_oe) |-> $past(i_pins.reg_ok, 8))
    else $error("host reset released too early");
  chk_hrst_low: assert property (
    !i_pins.reg_ok [*4] |-> o_host_reset_n_oe)
    else $error("host reset free with regulator down");
endmodule
bind bfa_ctrl bfa_chk chk_u (.*);

// ===== test/bfa_host_mdl.sv
// Purpose: host controller model on the register port
// Assumes: tasks are entered at a rising edge, one at a time
// Notes: released data shows the inverse of the last value
`timescale 1ns/10ps
module bfa_host_mdl
  import bfa_pkg::*;
(
  input wire logic i_clk,
  input wire logic [DW-1:0] i_rdata,
  output logic [AW-1:0] o_addr,
  output logic [DW-1:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  initial begin
    o_addr = '0;
    o_wdata = '0;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // extra edge so a following write never re-raises in the same step
  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
    @(posedge i_clk);
  endtask
  task automatic rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] d);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    @(posedge i_clk);
    d = i_rdata;
  endtask
  // settling wait is scaled down from real time
  task automatic clear_latch();
    repeat (4) @(posedge i_clk);
    wr_reg(A_OUT_CTRL, 8'h04);
    wr_reg(A_OUT_CTRL, 8'h00);
    repeat (2) @(posedge i_clk);
  endtask
endmodule

// ===== test/tb_top.sv
// Purpose: directed checks of the fault, alert and balance block
// Assumes: host model drives the register port
// Notes: host reset interval shortened to 20 cycles
`timescale 1ns/10ps
module tb_top;
  import bfa_pkg::*;
  localparam int RC = 20;
  logic clk, arst_n, wstb, rd, gain, amp, cal, gnd, charge_switch_drive, discharge_switch_drive, thr, aux;
  logic al_n, hr;
  logic [AW-1:0] addr;
  logic [DW-1:0] wd, rdat, rv;
  logic [NCELL-1:0] byp;
  bfa_pins_t pins;
  bfa_cells_t cells;
  int failures = 0;
  int n_checks = 0;
  bfa_host_mdl host_u (.i_clk(clk), .i_rdata(rdat), .o_addr(addr),
    .o_wdata(wd), .o_wr(wstb), .o_rd(rd));
  bfa_ctrl #(.P_RST_CYC(RC)) dut_u (.i_clk(clk), .i_arst_n(arst_n),
    .i_addr(addr), .i_wdata(wd), .i_wr(wstb), .i_rd(rd), .o_rdata(rdat),
    .i_pins(pins), .i_cells(cells), .o_current_gain_sel(gain),
    .o_current_amp_en(amp), .o_current_offset_cal(cal),
    .o_current_out_pin_gnd(gnd), .o_bypass_sel(byp),
    .o_charge_switch_drive(charge_switch_drive), .o_discharge_switch_drive(discharge_switch_drive),
    .o_thermistor_drive(thr), .o_aux_open_drain_out_oe(aux),
    .o_host_alert_n(al_n), .o_host_reset_n_oe(hr));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // wide enough for a full bypass word beside a drive bit
  task automatic chk(input string s, input logic [15:0] e,
    input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    host_u.wr_reg(a, d);
    cyc(2);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    cyc(5000);
    failures++;
    close_out();
  end
  initial begin
    arst_n = 1'b0;
    pins = '0;
    cells = '0;
    cyc(16);
    arst_n <= 1'b1;
    pins.reg_ok <= 1'b1;
    cyc(RC - 2);
    chk("hrst", 1, {al_n & gnd & hr});
    cyc(10);
    chk("hrst", 0, hr);
    pins.reg_ok <= 1'b0;
    cyc(4);
    chk("hrst", 1, hr);
    pins.reg_ok <= 1'b1;
    cyc(RC + 10);
    wr(A_STATE_CTRL, 8'h01);
    chk("gain", 1, gain);
    wr(A_STATE_CTRL, 8'h00);
    chk("gain", 0, gain);
    wr(A_FUNC_CTRL, 8'h02);
    chk("amp", 10'h1, {amp, cal, gnd});
    wr(A_FUNC_CTRL, 8'h03);
    chk("amp", 10'h6, {amp, cal, gnd});
    wr(A_FUNC_CTRL, 8'h05);
    chk("therm", 10'h9, {amp, cal, gnd, thr});
    cells <= {10'h0c4, 10'h0c4};
    cyc(6);
    chk("byp", 10'h084, byp);
    chk("chg", 0, charge_switch_drive);
    pins.mon_active <= 1'b1;
    cyc(5);
    chk("byp", 0, byp);
    pins.mon_active <= 1'b0;
    cells <= {10'h044, 10'h044};
    cyc(6);
    chk("byp", 10'h044, byp);
    // over level gone, still above hysteresis level: bypass holds
    cells <= {10'h000, 10'h044};
    cyc(6);
    chk("byp", 10'h044, byp);
    chk("chg", 0, charge_switch_drive);
    cells <= '0;
    cyc(6);
    chk("byp", 10'h001, {byp, charge_switch_drive});
    pins.therm_low <= 1'b1;
    cyc(5);
    chk("drv", 0, {charge_switch_drive, discharge_switch_drive});
    // undervoltage with zero-volt charge, regulator kept up
    pins <= 7'h13;
    cyc(5);
    chk("alert", 0, al_n);
    chk("aux", 1, aux);
    pins <= 7'h02;
    cyc(6);
    chk("alert", 1, al_n);
    wr(A_STATE_CTRL, 8'h80);
    wr(A_CELL_BAL, 8'h05);
    chk("byp", 10'h005, byp);
    wr(A_CELL_BAL, 8'h03);
    chk("byp", 10'h002, byp);
    wr(A_FUNC_CTRL, 8'h18);
    chk("byp", 10'h202, byp);
    wr(A_OUT_CTRL, 8'h08);
    chk("aux", 1, aux);
    pins.discharge_overcurrent <= 1'b1;
    cyc(5);
    pins.discharge_overcurrent <= 1'b0;
    cyc(5);
    chk("alert", 0, al_n);
    wr(A_OUT_CTRL, 8'h04);
    host_u.rd_reg(A_STATUS, rv);
    chk("stat", 10'h0a1, rv);
    cyc(3);
    chk("alert", 0, al_n);
    host_u.clear_latch();
    host_u.rd_reg(A_STATUS, rv);
    chk("stat", 10'h0e0, rv);
    cyc(3);
    chk("alert", 1, al_n);
    host_u.rd_reg(A_STATUS, rv);
    cyc(3);
    chk("alert", 1, al_n);
    wr(A_OUT_CTRL, 8'h03);
    chk("drv", 10'h3, {charge_switch_drive, discharge_switch_drive});
    pins.discharge_short <= 1'b1;
    cyc(5);
    chk("alert", 0, al_n);
    chk("drv", 0, {charge_switch_drive, discharge_switch_drive});
    close_out();
  end
endmodule
